// file: rtl/d_channel_arbiter_regs.svh
// constants of the d-channel arbiter: frame positions, fill, reset values
// assumes one serial port of 256 bits per frame, eight subscribers
`ifndef D_CHANNEL_ARBITER_REGS_SVH
`define D_CHANNEL_ARBITER_REGS_SVH

// d-channel sits at bit_pos[4:1] == 4'hc (bits 24 and 25 of a 32-bit group)
`define D_SLOT_NIBBLE     4'hc
// broadcast buffer is loaded at frame bits 0 and 1 (bit_pos[7:1] == 0)
`define BCAST_LOAD_POS    7'h00
`define FILL_BIT          1'b1
`define FILL_PAIR         2'h3
`define BIT_POS_STEP      8'h01
`define RST_BIT_POS       8'h00
`define RST_SUB           3'h0
`define RST_AVAIL         8'h00
`define RST_CFG_TARGET    3'h0
`define RST_CFG_GROUP     8'h00
`define RST_CFG_MASK      8'h00
`define RST_CFG_EXCL      8'h00
`define SUSPEND_FRAMES    8'h10

`endif

// file: rtl/d_channel_arbiter_pkg.sv
// types of the d-channel arbiter
// constants live in d_channel_arbiter_regs.svh
package d_channel_arbiter_pkg;

  typedef enum logic [3:0] {
    ARB_FULL    = 4'h1,
    ARB_SEL     = 4'h2,
    ARB_LIMITED = 4'h4,
    ARB_HALT    = 4'h8
  } arb_state_e;

  typedef struct packed {
    logic [2:0] single_target_select;
    logic       broadcast_enable;
    logic [7:0] broadcast_group_select;
    logic [7:0] channel_enable_mask;
    logic [7:0] exclusion_duration;
  } arb_cfg_s;

endpackage

// file: rtl/d_channel_arbiter.sv
// d-channel arbiter between an hdlc controller and eight subscriber
// d-channels of one time-slot serial port.
// assumes link_clk_i is the serial bit clock, fsc_i a one-cycle frame
// pulse on it, and the hdlc controller is strobed on the same clock.
//
// Summary of operation
// - single mode strobes hdlc two bits per frame into target d-channel.
// - two bits per 125 us frame give 16 kbit/s per subscriber.
// - hdlc with nothing pending gives all-ones fill to target.
// - broadcast copies hdlc bits to a buffer, sent to group.
// - broadcast with nothing pending buffers all-ones fill.
// - full state marks enabled subscribers available, monitors only those.
// - first zero selects subscriber, strobes it, starts suspend count.
// - a real received frame stops the suspend counter.
// - closing flag or abort stops strobing, enters limited state.
// - suspend underflow raises timeout flag, reports subscriber.
// - limited state blocks last served subscriber, monitors others.
// - exclusion lasts programmed frames, then full state again.
// - d bits are bits 7,6 of last slot of each group.
`timescale 1ns/1ns

`include "d_channel_arbiter_regs.svh"

module d_channel_arbiter #(
  parameter logic [7:0] SUSPEND_FRAMES = `SUSPEND_FRAMES
) (
  // system clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // configuration, system domain, quasi-static
  input  wire logic [2:0] single_target_select_i,
  input  wire logic       broadcast_enable_i,
  input  wire logic [7:0] broadcast_group_select_i,
  input  wire logic [7:0] channel_enable_mask_i,
  input  wire logic [7:0] exclusion_duration_i,
  // software controls and status, system domain
  input  wire logic       rx_reset_i,
  input  wire logic       timeout_clear_i,
  output logic            arbiter_timeout_flag_o,
  output logic [2:0]      arbiter_state_report_o,
  // serial link, link domain
  input  wire logic       link_clk_i,
  input  wire logic       fsc_i,
  input  wire logic       du_i,
  output logic            dd_o,
  output logic            dd_drive_o,
  output logic [7:0]      avail_o,
  // hdlc controller, link domain
  input  wire logic       tx_data_i,
  input  wire logic       tx_pending_i,
  output logic            tx_strobe_o,
  output logic            rx_strobe_o,
  output logic            rx_data_o,
  input  wire logic       rx_frame_seen_i,
  input  wire logic       rx_frame_end_i
);

  function automatic logic in_dchan(input logic [7:0] pos);
    in_dchan = (pos[4:1] == `D_SLOT_NIBBLE);
  endfunction

  function automatic logic [7:0] one_hot8(input logic [2:0] idx);
    one_hot8 = 8'h01 << idx;
  endfunction

  // ---------------- system domain ----------------
  d_channel_arbiter_pkg::arb_cfg_s cfg_m;
  logic                            rr_tgl;
  logic                            to_s1;
  logic                            to_s2;
  logic                            to_s3;
  logic                            to_seen;
  logic                            to_evt;
  logic                            to_tgl;
  logic [2:0]                      report;

  always_comb begin
    cfg_m.single_target_select   = single_target_select_i;
    cfg_m.broadcast_enable       = broadcast_enable_i;
    cfg_m.broadcast_group_select = broadcast_group_select_i;
    cfg_m.channel_enable_mask    = channel_enable_mask_i;
    cfg_m.exclusion_duration     = exclusion_duration_i;
  end

  // receiver reset request crosses as a toggle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rr_tgl <= 1'b0;
    end else if (rx_reset_i) begin
      rr_tgl <= ~rr_tgl;
    end
  end

  // timeout event from the link domain
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      to_s1   <= 1'b0;
      to_s2   <= 1'b0;
      to_s3   <= 1'b0;
      to_seen <= 1'b0;
    end else begin
      to_s1 <= to_tgl;
      to_s2 <= to_s1;
      to_s3 <= to_s2;
      if (to_s2 == to_s3) begin
        to_seen <= to_s3;
      end
    end
  end

  assign to_evt = (to_s2 == to_s3) && (to_s3 != to_seen);

  // sticky flag: a new event wins over a clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      arbiter_timeout_flag_o <= 1'b0;
      arbiter_state_report_o <= `RST_SUB;
    end else begin
      if (to_evt) begin
        arbiter_timeout_flag_o <= 1'b1;
        arbiter_state_report_o <= report;
      end else if (timeout_clear_i) begin
        arbiter_timeout_flag_o <= 1'b0;
      end
    end
  end

  // ---------------- link domain ----------------
  logic                            lrst_a;
  logic                            lrst_b;
  logic                            lrst_c;
  logic                            link_rst;
  d_channel_arbiter_pkg::arb_cfg_s cfg_l1;
  d_channel_arbiter_pkg::arb_cfg_s cfg_l2;
  d_channel_arbiter_pkg::arb_cfg_s cfg_l3;
  d_channel_arbiter_pkg::arb_cfg_s cfg;
  logic                            rr_l1;
  logic                            rr_l2;
  logic                            rr_l3;
  logic                            rr_seen;
  logic                            rr_evt;
  logic [7:0]                      bit_pos;
  logic [2:0]                      sub;
  logic                            at_d;
  d_channel_arbiter_pkg::arb_state_e state;
  logic [2:0]                      sel;
  logic [2:0]                      excl;
  logic [7:0]                      susp;
  logic                            susp_run;
  logic [7:0]                      excl_cnt;
  logic [7:0]                      monitored;
  logic [7:0]                      next_avail;
  logic                            start_hit;
  logic                            tx_take;
  logic                            tx_bit;
  logic [1:0]                      bcbuf;

  // reset brought onto the link clock
  always_ff @(posedge link_clk_i) begin
    lrst_a <= rst_i;
    lrst_b <= lrst_a;
    lrst_c <= lrst_b;
  end

  assign link_rst = lrst_c;

  // configuration taken once two late stages agree
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      cfg_l1 <= '0;
      cfg_l2 <= '0;
      cfg_l3 <= '0;
      cfg.single_target_select   <= `RST_CFG_TARGET;
      cfg.broadcast_enable       <= 1'b0;
      cfg.broadcast_group_select <= `RST_CFG_GROUP;
      cfg.channel_enable_mask    <= `RST_CFG_MASK;
      cfg.exclusion_duration     <= `RST_CFG_EXCL;
    end else begin
      cfg_l1 <= cfg_m;
      cfg_l2 <= cfg_l1;
      cfg_l3 <= cfg_l2;
      if (cfg_l2 == cfg_l3) begin
        cfg <= cfg_l3;
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      rr_l1   <= 1'b0;
      rr_l2   <= 1'b0;
      rr_l3   <= 1'b0;
      rr_seen <= 1'b0;
    end else begin
      rr_l1 <= rr_tgl;
      rr_l2 <= rr_l1;
      rr_l3 <= rr_l2;
      if (rr_l2 == rr_l3) begin
        rr_seen <= rr_l3;
      end
    end
  end

  assign rr_evt = (rr_l2 == rr_l3) && (rr_l3 != rr_seen);

  // bit position within the 256-bit frame
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      bit_pos <= `RST_BIT_POS;
    end else if (fsc_i) begin
      bit_pos <= `RST_BIT_POS;
    end else begin
      bit_pos <= bit_pos + `BIT_POS_STEP;
    end
  end

  assign sub  = bit_pos[7:5];
  assign at_d = in_dchan(bit_pos);

  // who is watched and who gets the available code
  always_comb begin
    monitored  = 8'h00;
    next_avail = `RST_AVAIL;
    case (state)
      d_channel_arbiter_pkg::ARB_FULL: begin
        monitored  = cfg.channel_enable_mask;
        next_avail = cfg.channel_enable_mask;
      end
      d_channel_arbiter_pkg::ARB_LIMITED: begin
        monitored  = cfg.channel_enable_mask & ~one_hot8(excl);
        next_avail = cfg.channel_enable_mask & ~one_hot8(excl);
      end
      d_channel_arbiter_pkg::ARB_SEL: begin
        next_avail = cfg.channel_enable_mask & one_hot8(sel);
      end
      default: begin
        monitored  = 8'h00;
        next_avail = `RST_AVAIL;
      end
    endcase
  end

  assign start_hit = at_d && monitored[sub] && !du_i;

  // arbitration state machine
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      state    <= d_channel_arbiter_pkg::ARB_FULL;
      sel      <= `RST_SUB;
      excl     <= `RST_SUB;
      susp     <= SUSPEND_FRAMES;
      susp_run <= 1'b0;
      excl_cnt <= `RST_CFG_EXCL;
      to_tgl   <= 1'b0;
      report   <= `RST_SUB;
    end else if (rr_evt) begin
      state    <= d_channel_arbiter_pkg::ARB_FULL;
      susp_run <= 1'b0;
    end else begin
      case (state)
        d_channel_arbiter_pkg::ARB_FULL,
        d_channel_arbiter_pkg::ARB_LIMITED: begin
          if (start_hit) begin
            state    <= d_channel_arbiter_pkg::ARB_SEL;
            sel      <= sub;
            susp     <= SUSPEND_FRAMES;
            susp_run <= 1'b1;
          end else if (state == d_channel_arbiter_pkg::ARB_LIMITED && fsc_i) begin
            if (excl_cnt == 8'h00) begin
              state <= d_channel_arbiter_pkg::ARB_FULL;
            end else begin
              excl_cnt <= excl_cnt - 8'h01;
            end
          end
        end
        d_channel_arbiter_pkg::ARB_SEL: begin
          if (rx_frame_seen_i) begin
            susp_run <= 1'b0;
          end
          if (rx_frame_end_i) begin
            state    <= d_channel_arbiter_pkg::ARB_LIMITED;
            excl     <= sel;
            excl_cnt <= cfg.exclusion_duration;
            susp_run <= 1'b0;
          end else if (susp_run && !rx_frame_seen_i && fsc_i) begin
            if (susp == 8'h00) begin
              state  <= d_channel_arbiter_pkg::ARB_HALT;
              to_tgl <= ~to_tgl;
              report <= sel;
            end else begin
              susp <= susp - 8'h01;
            end
          end
        end
        default: begin
          state <= d_channel_arbiter_pkg::ARB_HALT;
        end
      endcase
    end
  end

  // upstream strobe to the hdlc receiver
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      rx_strobe_o <= 1'b0;
      rx_data_o   <= `FILL_BIT;
      avail_o     <= `RST_AVAIL;
    end else begin
      rx_strobe_o <= start_hit ||
                     (at_d && state == d_channel_arbiter_pkg::ARB_SEL &&
                      sub == sel && !rx_frame_end_i);
      rx_data_o   <= du_i;
      avail_o     <= next_avail;
    end
  end

  // downstream transmit: single target or broadcast buffer
  assign tx_take = cfg.broadcast_enable ?
                   (bit_pos[7:1] == `BCAST_LOAD_POS) :
                   (at_d && sub == cfg.single_target_select);
  assign tx_bit  = tx_pending_i ? tx_data_i : `FILL_BIT;

  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      tx_strobe_o <= 1'b0;
      bcbuf       <= `FILL_PAIR;
      dd_o        <= `FILL_BIT;
      dd_drive_o  <= 1'b0;
    end else begin
      tx_strobe_o <= tx_take;
      if (cfg.broadcast_enable && tx_take) begin
        bcbuf[bit_pos[0]] <= tx_bit;
      end
      if (!cfg.broadcast_enable && tx_take) begin
        dd_o       <= tx_bit;
        dd_drive_o <= 1'b1;
      end else if (cfg.broadcast_enable && at_d &&
                   cfg.broadcast_group_select[sub]) begin
        dd_o       <= bcbuf[bit_pos[0]];
        dd_drive_o <= 1'b1;
      end else begin
        dd_o       <= `FILL_BIT;
        dd_drive_o <= 1'b0;
      end
    end
  end

endmodule

// file: verif/d_channel_arbiter_checker.sv
// checker: port timing relations of the d-channel arbiter
// assumes bind into d_channel_arbiter; link outputs are registered
`timescale 1ns/1ns
module d_channel_arbiter_checker #(
  parameter logic [7:0] SUSPEND_FRAMES = 8'h10
) (
  // system side
  input wire logic       mclk_i,
  input wire logic       rst_i,
  input wire logic       timeout_clear_i,
  input wire logic       arbiter_timeout_flag_o,
  // link side
  input wire logic       link_clk_i,
  input wire logic       du_i,
  input wire logic       tx_pending_i,
  input wire logic       dd_o,
  input wire logic       dd_drive_o,
  input wire logic [7:0] avail_o,
  input wire logic       tx_strobe_o,
  input wire logic       rx_strobe_o,
  input wire logic       rx_data_o
);
  sequence pulse_pair(logic s);
    s ##1 !s;
  endsequence

  tx_pair_a: assert property (@(posedge link_clk_i)
    disable iff (rst_i) $rose(tx_strobe_o) |=> pulse_pair(tx_strobe_o))
    else $error("transmit strobe not two cycles");
  dd_pair_a: assert property (@(posedge link_clk_i)
    disable iff (rst_i) $rose(dd_drive_o) |=> pulse_pair(dd_drive_o))
    else $error("downstream d bits not a pair");
  fill_ones_a: assert property (@(posedge link_clk_i)
    disable iff (rst_i)
    tx_strobe_o && dd_drive_o && !$past(tx_pending_i) |-> dd_o)
    else $error("fill bit not one");
  idle_high_a: assert property (@(posedge link_clk_i)
    disable iff (rst_i) !dd_drive_o |-> dd_o)
    else $error("undriven d bit not one");
  rx_copy_a: assert property (@(posedge link_clk_i)
    disable iff (rst_i) rx_strobe_o |-> rx_data_o == $past(du_i))
    else $error("receive bit differs from line");
  rx_pair_a: assert property (@(posedge link_clk_i)
    disable iff (rst_i) $rose(rx_strobe_o) |=> pulse_pair(rx_strobe_o))
    else $error("receive strobe not two cycles");
  sel_one_a: assert property (@(posedge link_clk_i)
    disable iff (rst_i)
    rx_strobe_o && $past(rx_strobe_o) |-> $onehot(avail_o))
    else $error("selected state offers several subscribers");
  flag_hold_a: assert property (@(posedge mclk_i)
    disable iff (rst_i)
    arbiter_timeout_flag_o && !timeout_clear_i |=> arbiter_timeout_flag_o)
    else $error("timeout flag dropped without clear");
endmodule

bind d_channel_arbiter d_channel_arbiter_checker #(
  .SUSPEND_FRAMES(SUSPEND_FRAMES)
) chk (
  .mclk_i, .rst_i, .timeout_clear_i, .arbiter_timeout_flag_o,
  .link_clk_i, .du_i, .tx_pending_i, .dd_o, .dd_drive_o, .avail_o,
  .tx_strobe_o, .rx_strobe_o, .rx_data_o
);

// file: verif/sub_model.sv
// subscriber side: upstream d bits of eight subscribers on one port
// assumes pos_i is the frame bit position, 0 the cycle after the frame pulse
`timescale 1ns/1ns
module sub_model (
  // link timing
  input  wire logic       link_clk_i,
  input  wire logic [7:0] pos_i,
  // subscriber n sends zeros while bit n is set
  input  wire logic [7:0] zero_mask_i,
  // upstream line
  output logic            du_o
);
  logic noise = 1'b0;
  logic d_slot;
  always @(posedge link_clk_i) noise <= ~noise;
  // d bits at bits 7,6 of each group's last slot
  assign d_slot = (pos_i[4:1] == 4'hc);
  // idle fill all ones, other slots a changing pattern
  assign du_o = d_slot ? ~zero_mask_i[pos_i[7:5]] : noise;
endmodule

// file: verif/d_channel_arbiter_tb_top.sv
// testbench: single, broadcast and receive arbitration at the ports
// assumes sub_model on the upstream line and the bound checker
`timescale 1ns/1ns
module d_channel_arbiter_tb_top;
  typedef struct packed {
    logic       bc;
    logic [2:0] tgt;
    logic [7:0] grp;
    logic       pend;
    logic [1:0] pat;
    logic [7:0] drv;
    logic [7:0] first;
    logic [1:0] bits;
  } row_s;
  row_s rows [6] = '{
    '{1'b0, 3'h0, 8'h00, 1'b1, 2'h1, 8'h02, 8'h19, 2'h1},
    '{1'b0, 3'h7, 8'h00, 1'b1, 2'h2, 8'h02, 8'hf9, 2'h2},
    '{1'b0, 3'h3, 8'h00, 1'b0, 2'h0, 8'h02, 8'h79, 2'h3},
    '{1'b1, 3'h0, 8'h81, 1'b1, 2'h2, 8'h04, 8'h19, 2'h2},
    '{1'b1, 3'h0, 8'h24, 1'b0, 2'h0, 8'h04, 8'h59, 2'h3},
    '{1'b1, 3'h0, 8'hff, 1'b1, 2'h1, 8'h10, 8'h19, 2'h1}};
  d_channel_arbiter_pkg::arb_cfg_s cfg = '0;
  logic       mclk_i = 1'b0;
  logic       link_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       go = 1'b0;
  logic       rx_reset_i = 1'b0;
  logic       timeout_clear_i = 1'b0;
  logic       tx_pending_i = 1'b0;
  logic       rx_frame_seen_i = 1'b0;
  logic       rx_frame_end_i = 1'b0;
  logic [1:0] pat = 2'h3;
  logic [7:0] zero_mask = 8'h00;
  logic [7:0] pos_q = 8'h00;
  logic [7:0] drv_c, tx_c, rx_c, first_p, f_drv, f_tx, f_rx, f_first;
  logic [1:0] bits, rxb, f_bits, f_rxb;
  logic       fsc_i, tx_data_i, du_i, flag, dd_o, dd_drive_o;
  logic       tx_strobe_o, rx_strobe_o, rx_data_o;
  logic [2:0] report;
  logic [7:0] avail_o;
  int         frames = 0;
  int         checks = 0;
  int         failures = 0;
  int         cyc = 0;

  always #50 mclk_i = ~mclk_i;
  always #3 link_clk_i = ~link_clk_i;
  // the arbiter counts bit 0 from the cycle after the frame pulse
  assign fsc_i = go && (pos_q == 8'hff);
  // hdlc stand-in: clock mode 3, sends the pat bits even when idle
  assign tx_data_i = pat[~pos_q[0]];

  d_channel_arbiter #(.SUSPEND_FRAMES(8'h02)) uut (
    .mclk_i, .rst_i, .rx_reset_i, .timeout_clear_i,
    .single_target_select_i(cfg.single_target_select),
    .broadcast_enable_i(cfg.broadcast_enable),
    .broadcast_group_select_i(cfg.broadcast_group_select),
    .channel_enable_mask_i(cfg.channel_enable_mask),
    .exclusion_duration_i(cfg.exclusion_duration),
    .arbiter_timeout_flag_o(flag), .arbiter_state_report_o(report),
    .link_clk_i, .fsc_i, .du_i, .dd_o, .dd_drive_o, .avail_o,
    .tx_data_i, .tx_pending_i, .tx_strobe_o, .rx_strobe_o, .rx_data_o,
    .rx_frame_seen_i, .rx_frame_end_i);
  sub_model sub (.link_clk_i, .pos_i(pos_q), .zero_mask_i(zero_mask),
    .du_o(du_i));

  // per-frame tallies of what the arbiter put out
  always @(posedge link_clk_i) begin
    if (go) pos_q <= pos_q + 8'h01;
    if (pos_q == 8'h00) begin
      {f_drv, f_tx, f_rx, f_first} <= {drv_c, tx_c, rx_c, first_p};
      {f_bits, f_rxb} <= {bits, rxb};
      {drv_c, tx_c, rx_c} <= '0;
      frames <= frames + 1;
    end else begin
      drv_c <= drv_c + {7'h00, dd_drive_o};
      tx_c <= tx_c + {7'h00, tx_strobe_o};
      rx_c <= rx_c + {7'h00, rx_strobe_o};
      if (dd_drive_o && drv_c == 8'h00) first_p <= pos_q;
      if (dd_drive_o) bits <= {bits[0], dd_o};
      if (rx_strobe_o) rxb <= {rxb[0], rx_data_o};
    end
  end

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // mclk edge in the quiet gap between subscribers 3 and 4
  task automatic at_gap();
    int k = 0;
    do @(posedge mclk_i);
    while (!(pos_q >= 8'h7d && pos_q < 8'h8e) && ++k < 40);
  endtask

  task automatic wait_frames(input int n);
    int t = frames + n;
    for (int k = 0; k < 40 * n && frames < t; k++) @(posedge mclk_i);
  endtask

  // receiver stand-in: one frame-seen or frame-end pulse at bit 8'h96
  task automatic hdlc_pulse(input logic fin);
    for (int k = 0; k < 300 && pos_q != 8'h96; k++) @(posedge link_clk_i);
    rx_frame_seen_i <= !fin;
    rx_frame_end_i <= fin;
    @(posedge link_clk_i);
    {rx_frame_seen_i, rx_frame_end_i} <= 2'b00;
  endtask

  task automatic mclk_pulse(input logic clr);
    at_gap();
    timeout_clear_i <= clr;
    rx_reset_i <= !clr;
    @(posedge mclk_i);
    {timeout_clear_i, rx_reset_i} <= 2'b00;
  endtask

  task automatic zero_frame(input logic [7:0] m);
    at_gap();
    zero_mask <= m;
    wait_frames(1);
    at_gap();
    zero_mask <= 8'h00;
  endtask

  initial begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    go <= 1'b1;
    check("flag after reset", {7'h00, flag}, 8'h00);
    check("avail empty mask", avail_o, 8'h00);
    for (int i = 0; i < 6; i++) begin
      at_gap();
      cfg.broadcast_enable <= rows[i].bc;
      cfg.single_target_select <= rows[i].tgt;
      cfg.broadcast_group_select <= rows[i].grp;
      tx_pending_i <= rows[i].pend;
      pat <= rows[i].pat;
      wait_frames(3);
      check("drive count", f_drv, rows[i].drv);
      check("first d position", f_first, rows[i].first);
      check("d bits", {6'h00, f_bits}, {6'h00, rows[i].bits});
      check("tx strobes", f_tx, 8'h02);
    end
    at_gap();
    cfg.broadcast_enable <= 1'b0;
    cfg.channel_enable_mask <= 8'h0a;
    cfg.exclusion_duration <= 8'h02;
    wait_frames(2);
    check("avail full", avail_o, 8'h0a);
    zero_frame(8'h08);
    hdlc_pulse(1'b0);
    wait_frames(1);
    check("rx start bits", {6'h00, f_rxb}, 8'h00);
    check("rx strobes", f_rx, 8'h02);
    check("avail selected", avail_o, 8'h08);
    wait_frames(4);
    check("flag while receiving", {7'h00, flag}, 8'h00);
    check("rx idle bits", {6'h00, f_rxb}, 8'h03);
    hdlc_pulse(1'b1);
    wait_frames(2);
    check("avail limited", avail_o, 8'h02);
    check("rx after end", f_rx, 8'h00);
    wait_frames(3);
    check("avail after exclusion", avail_o, 8'h0a);
    zero_frame(8'h02);
    wait_frames(6);
    check("timeout flag", {7'h00, flag}, 8'h01);
    check("timeout report", {5'h00, report}, 8'h01);
    check("avail halted", avail_o, 8'h00);
    mclk_pulse(1'b1);
    repeat (2) @(posedge mclk_i);
    check("flag cleared", {7'h00, flag}, 8'h00);
    mclk_pulse(1'b0);
    wait_frames(2);
    check("avail after rx reset", avail_o, 8'h0a);
    at_gap();
    cfg.channel_enable_mask <= 8'h00;
    zero_mask <= 8'hff;
    wait_frames(3);
    check("rx with empty mask", f_rx, 8'h00);
    check("avail with empty mask", avail_o, 8'h00);
    end_sim();
  end
endmodule
